// File: verilog/ppo_pkg.sv
// Constants shared by the port pin override and sleep clamp block
package ppo_pkg;
   // Port geometry
   localparam int unsigned PPO_NPIN = 8;
   localparam int unsigned PPO_AW   = 3;

   // Register indices on the plain register port
   localparam logic [PPO_AW-1:0] PPO_IDX_INPUT = 3'h0;
   localparam logic [PPO_AW-1:0] PPO_IDX_DIR   = 3'h1;
   localparam logic [PPO_AW-1:0] PPO_IDX_OUT   = 3'h2;
   localparam logic [PPO_AW-1:0] PPO_IDX_CTRL  = 3'h3;
   localparam logic [PPO_AW-1:0] PPO_IDX_FLAG  = 3'h4;

   // Control register fields
   localparam int unsigned PPO_CTRL_PUDIS_BIT = 0;
   localparam int unsigned PPO_CTRL_SNS_LO  = 1;
   localparam int unsigned PPO_CTRL_SNS_W   = 2;

   // Reset values
   localparam logic [PPO_NPIN-1:0]   PPO_RST_BYTE = 8'h00;

   // Edge sense encodings for the external interrupt flags
   typedef enum logic [1:0] {
      PPO_SNS_LEVEL,
      PPO_SNS_ANY,
      PPO_SNS_FALL,
      PPO_SNS_RISE
   } ppo_sense_t;
endpackage

// File: verilog/ppo_inlatch.sv
// Input clamp and clock-high transparent capture latch for every pin
`timescale 1ns/1ns
`default_nettype none
module ppo_inlatch
   import ppo_pkg::*;
(
   // Clock
   input  wire logic                i_core_clk,
   // Pad side
   input  wire logic [PPO_NPIN-1:0] i_pad,
   input  wire logic [PPO_NPIN-1:0] i_inen,
   // Core side
   output logic      [PPO_NPIN-1:0] o_tap,
   output logic      [PPO_NPIN-1:0] o_latched
);

   // Clamp to ground ahead of the Schmitt trigger; tap before any synchroniser
   assign o_tap = i_pad & i_inen;

   // Transparent while the clock is high, holds while low
   always_latch begin
      if (i_core_clk) begin
         o_latched = o_tap;
      end
   end
endmodule // ppo_inlatch
`default_nettype wire

// File: verilog/ppo_port.sv
// One 8-pin general-purpose port with peripheral overrides and sleep clamp
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module ppo_port
   import ppo_pkg::*;
(
   // Clock and reset
   input  wire logic                i_core_clk,
   input  wire logic                i_nrst,
   // Register port
   input  wire logic [PPO_AW-1:0]   i_addr,
   input  wire logic [7:0]          i_wdata,
   input  wire logic                i_wr,
   input  wire logic                i_rd,
   output logic      [7:0]          o_rdata,
   // Shared system controls
   input  wire logic                i_sleep_clamp,
   // Per-pin peripheral overrides, tied low where a pin lacks the function
   input  wire logic [PPO_NPIN-1:0] i_pullup_ovr_en,
   input  wire logic [PPO_NPIN-1:0] i_pullup_ovr_val,
   input  wire logic [PPO_NPIN-1:0] i_dir_ovr_en,
   input  wire logic [PPO_NPIN-1:0] i_dir_ovr_val,
   input  wire logic [PPO_NPIN-1:0] i_outval_ovr_en,
   input  wire logic [PPO_NPIN-1:0] i_outval_ovr_val,
   input  wire logic [PPO_NPIN-1:0] i_outbit_toggle_ovr_en,
   input  wire logic [PPO_NPIN-1:0] i_inen_ovr_en,
   input  wire logic [PPO_NPIN-1:0] i_inen_ovr_val,
   input  wire logic [PPO_NPIN-1:0] i_ext_int_en,
   output logic      [PPO_NPIN-1:0] o_alt_func_input_tap,
   // Pad
   input  wire logic [PPO_NPIN-1:0] i_pad,
   output logic      [PPO_NPIN-1:0] o_pad,
   output logic      [PPO_NPIN-1:0] o_pad_oe,
   output logic      [PPO_NPIN-1:0] o_pullup_en,
   // Status
   output logic      [PPO_NPIN-1:0] o_ext_int_flag
);

   // All state in one record
   typedef struct packed {
      logic [PPO_NPIN-1:0] dir;
      logic [PPO_NPIN-1:0] outb;
      logic [PPO_NPIN-1:0] inb;
      logic [PPO_NPIN-1:0] flag;
      logic                pu_dis;
      ppo_sense_t          sense;
      logic [7:0]          rdata;
   } ppo_state_t;

   ppo_state_t st_r;
   ppo_state_t st_nxt;

   logic [PPO_NPIN-1:0] inen;
   logic [PPO_NPIN-1:0] latched;
   logic [PPO_NPIN-1:0] dir_eff;
   logic [PPO_NPIN-1:0] toggle;
   logic [PPO_NPIN-1:0] edge_ev;
   logic [PPO_NPIN-1:0] flag_clr;

   // Edge event for one pin under the chosen sense
   function automatic logic ppo_edge(input logic prev, input logic cur, input ppo_sense_t sns);
      logic ev;
      ev = 1'b0;
      unique case (sns)
         PPO_SNS_LEVEL: ev = 1'b0;
         PPO_SNS_ANY:   ev = prev ^ cur;
         PPO_SNS_FALL:  ev = prev & ~cur;
         PPO_SNS_RISE:  ev = ~prev & cur;
      endcase
      return ev;
   endfunction

   // Input enable: enabled interrupt pins stay live in sleep
   assign inen = i_inen_ovr_en & i_inen_ovr_val
               | ~i_inen_ovr_en & ~({PPO_NPIN{i_sleep_clamp}} & ~i_ext_int_en);

   // Clamp, tap and capture latch
   ppo_inlatch u_inlatch (
      .i_core_clk (i_core_clk),
      .i_pad      (i_pad),
      .i_inen     (inen),
      .o_tap      (o_alt_func_input_tap),
      .o_latched  (latched)
   );

   // Pad drive; reset gating is combinational so no clock is needed
   assign dir_eff  = (i_dir_ovr_en & i_dir_ovr_val) | (~i_dir_ovr_en & st_r.dir);
   assign o_pad_oe = dir_eff & {PPO_NPIN{i_nrst}};
   assign o_pad    = (i_outval_ovr_en & i_outval_ovr_val) | (~i_outval_ovr_en & st_r.outb);

   // Pull-up: override, else input with output bit set and pull-ups allowed
   assign o_pullup_en = ((i_pullup_ovr_en & i_pullup_ovr_val)
                       | (~i_pullup_ovr_en & ~st_r.dir & st_r.outb & {PPO_NPIN{~st_r.pu_dis}}))
                       & {PPO_NPIN{i_nrst}};

   assign o_rdata        = st_r.rdata;
   assign o_ext_int_flag = st_r.flag;

   // Next-state logic
   always_comb begin
      st_nxt = st_r;
      toggle = i_outbit_toggle_ovr_en;
      flag_clr = '0;
      st_nxt.inb = latched;
      for (int i = 0; i < PPO_NPIN; i++) begin
         // Clamp release after sleep shows as a rising input edge
         edge_ev[i] = ppo_edge(st_r.inb[i], latched[i], st_r.sense);
      end
      if (i_wr) begin
         unique case (i_addr)
            PPO_IDX_INPUT: toggle = toggle | i_wdata;
            PPO_IDX_DIR:   st_nxt.dir = i_wdata;
            PPO_IDX_OUT:   st_nxt.outb = i_wdata;
            PPO_IDX_CTRL: begin
               st_nxt.pu_dis = i_wdata[PPO_CTRL_PUDIS_BIT];
               st_nxt.sense = ppo_sense_t'(i_wdata[PPO_CTRL_SNS_LO +: PPO_CTRL_SNS_W]);
            end
            PPO_IDX_FLAG:  flag_clr = i_wdata;
            default: ;
         endcase
      end
      // Toggle applies after any plain write of the output bits
      st_nxt.outb = st_nxt.outb ^ toggle;
      // New event wins over a clear in the same cycle
      st_nxt.flag = (st_r.flag & ~flag_clr) | edge_ev;
      // Read data stands only in the cycle after the strobe
      st_nxt.rdata = 8'h00;
      if (i_rd) begin
         unique case (i_addr)
            PPO_IDX_INPUT: st_nxt.rdata = st_r.inb;
            PPO_IDX_DIR:   st_nxt.rdata = st_r.dir;
            PPO_IDX_OUT:   st_nxt.rdata = st_r.outb;
            PPO_IDX_CTRL: begin
               st_nxt.rdata[PPO_CTRL_PUDIS_BIT] = st_r.pu_dis;
               st_nxt.rdata[PPO_CTRL_SNS_LO +: PPO_CTRL_SNS_W] = st_r.sense;
            end
            PPO_IDX_FLAG:  st_nxt.rdata = st_r.flag;
            default:       st_nxt.rdata = 8'h00;
         endcase
      end
   end

   // State register; everything resets to inputs without pull-ups
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_r <= '{dir: PPO_RST_BYTE, outb: PPO_RST_BYTE, inb: PPO_RST_BYTE,
                   flag: PPO_RST_BYTE, pu_dis: 1'b0, sense: PPO_SNS_LEVEL, rdata: 8'h00};
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule // ppo_port
`default_nettype wire

// File: testbench/ppo_pad_model.sv
// External circuitry seen by the port pads
`timescale 1ns/1ns
`default_nettype none
module ppo_pad_model (
   // Clock
   input  wire logic       i_core_clk,
   // Device side of the pad
   input  wire logic [7:0] i_out,
   input  wire logic [7:0] i_oe,
   input  wire logic [7:0] i_pu,
   // External source
   input  wire logic [7:0] i_ext_en,
   input  wire logic [7:0] i_ext_val,
   output logic      [7:0] o_pad
);
   logic [7:0] flt_r = 8'h00;
   // Floating pins wander so a stale level never passes for a drive
   always @(posedge i_core_clk) flt_r <= ~flt_r;
   // Device driver wins, then the outside source, then the pull-up
   assign o_pad = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext_val) | (~i_oe & ~i_ext_en & (i_pu | flt_r));
endmodule // ppo_pad_model
`default_nettype wire

// File: testbench/ppo_port_sva.sv
// Assertions on the port pin override and sleep clamp ports
`timescale 1ns/1ns
`default_nettype none
module ppo_port_sva
   import ppo_pkg::*;
(
   // Clock, reset, sleep clamp, register port
   input wire logic i_core_clk, i_nrst, i_rd, i_wr, i_sleep_clamp,
   input wire logic [PPO_AW-1:0] i_addr,
   input wire logic [7:0] o_rdata,
   // Overrides and pad
   input wire logic [PPO_NPIN-1:0] i_pullup_ovr_en, i_pullup_ovr_val, i_dir_ovr_en, i_dir_ovr_val,
   input wire logic [PPO_NPIN-1:0] i_outval_ovr_en, i_outval_ovr_val, i_outbit_toggle_ovr_en,
   input wire logic [PPO_NPIN-1:0] i_inen_ovr_en, i_ext_int_en, o_alt_func_input_tap,
   input wire logic [PPO_NPIN-1:0] i_pad, o_pad, o_pad_oe, o_pullup_en
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);
   // Pad quiet and unclamped over the whole capture path
   sequence s_quiet;
      ($stable(i_pad) && !i_sleep_clamp && i_inen_ovr_en == 8'h00) [*3];
   endsequence
   // Toggle on a driven pin with no write competing
   sequence s_tgl;
      i_outbit_toggle_ovr_en[0] && o_pad_oe[0] && !i_outval_ovr_en[0] && !i_wr ##1 !i_outval_ovr_en[0];
   endsequence
   a_pu_ovr: assert property (
      (o_pullup_en & i_pullup_ovr_en) == (i_pullup_ovr_val & i_pullup_ovr_en)) else $error("pull-up off override");
   a_drv_ovr: assert property (
      (o_pad_oe & i_dir_ovr_en) == (i_dir_ovr_val & i_dir_ovr_en)) else $error("driver off override");
   a_val_ovr: assert property (
      (o_pad & o_pad_oe & i_outval_ovr_en) == (i_outval_ovr_val & o_pad_oe & i_outval_ovr_en)) else $error("value");
   a_tgl_out: assert property (s_tgl |-> o_pad[0] != $past(o_pad[0])) else $error("no toggle");
   a_tap_clamp: assert property (
      i_sleep_clamp |-> (o_alt_func_input_tap & ~i_ext_int_en & ~i_inen_ovr_en) == 8'h00) else $error("no clamp");
   a_clamp_lift: assert property (
      (o_alt_func_input_tap & i_ext_int_en & ~i_inen_ovr_en) == (i_pad & i_ext_int_en & ~i_inen_ovr_en))
      else $error("clamp kept");
   a_pin_sync: assert property (
      s_quiet ##0 (i_rd && i_addr == PPO_IDX_INPUT) |=> o_rdata == $past(i_pad)) else $error("input bit");
   a_rd_idle: assert property (!i_rd |=> o_rdata == 8'h00) else $error("read data outside slot");
endmodule // ppo_port_sva
bind ppo_port ppo_port_sva i_sva (.*);
`default_nettype wire

// File: testbench/port_pin_override_and_sleep_clamp_tb.sv
// Self-checking bench for the port pin override and sleep clamp block
`timescale 1ns/1ns
`default_nettype none
module port_pin_override_and_sleep_clamp_tb
   import ppo_pkg::*;
;
   logic clk = 1'b0, nrst, wr_s, rd_s, slp;
   logic [2:0] addr;
   logic [7:0] wd, pu_e, pu_v, dd_e, dd_v, pv_e, pv_v, tg, ie_e, ie_v, xe, xen, xv;
   wire  [7:0] pad, opad, oe, pu, tap, flag, rdata;
   int fail_count = 0, check_count = 0, cyc = 0;
   always #4 clk = ~clk;
   ppo_port i_dut (.i_core_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wd), .i_wr(wr_s), .i_rd(rd_s),
      .o_rdata(rdata), .i_sleep_clamp(slp), .i_pullup_ovr_en(pu_e), .i_pullup_ovr_val(pu_v),
      .i_dir_ovr_en(dd_e), .i_dir_ovr_val(dd_v), .i_outval_ovr_en(pv_e), .i_outval_ovr_val(pv_v),
      .i_outbit_toggle_ovr_en(tg), .i_inen_ovr_en(ie_e), .i_inen_ovr_val(ie_v), .i_ext_int_en(xe),
      .o_alt_func_input_tap(tap), .i_pad(pad), .o_pad(opad), .o_pad_oe(oe), .o_pullup_en(pu), .o_ext_int_flag(flag));
   ppo_pad_model i_pad_mdl (.i_core_clk(clk), .i_out(opad), .i_oe(oe), .i_pu(pu), .i_ext_en(xen), .i_ext_val(xv),
      .o_pad(pad));
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Bus cycles: one strobe cycle, read data in the slot after it
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk) {addr, wd, wr_s} <= {a, d, 1'b1};
      @(posedge clk) wr_s <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk) {addr, rd_s} <= {a, 1'b1};
      @(posedge clk) rd_s <= 1'b0;
      #1 chk("rdata", e, rdata);
   endtask
   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         finish_test();
      end
   end
   task automatic t_reset();
      wr(PPO_IDX_DIR, 8'h0F);
      wr(PPO_IDX_OUT, 8'hF0);
      chk("pullup", 8'hF0, pu);
      @(posedge clk) {nrst, dd_e, dd_v} <= {1'b0, 8'hFF, 8'hFF};
      #1 chk("oe", 8'h00, oe);
      chk("pullup", 8'h00, pu);
      @(posedge clk) {nrst, dd_e, dd_v} <= {1'b1, 16'h0000};
   endtask
   task automatic t_gpio();
      wr(PPO_IDX_DIR, 8'h0F);
      wr(PPO_IDX_OUT, 8'hA5);
      chk("oe", 8'h0F, oe);
      chk("pad", 8'h05, opad & oe);
      wr(PPO_IDX_INPUT, 8'h03);
      rd(PPO_IDX_OUT, 8'hA6);
      rd(3'h5, 8'h00);
   endtask
   task automatic t_ovr();
      wr(PPO_IDX_DIR, 8'h00);
      wr(PPO_IDX_OUT, 8'hFF);
      chk("pullup", 8'hFF, pu);
      wr(PPO_IDX_CTRL, 8'h01);
      @(posedge clk) {pu_e, pu_v, dd_e, dd_v, pv_e} <= {8'h0F, 8'h05, 8'hF1, 8'h31, 8'h10};
      #1 chk("pullup", 8'h05, pu);
      chk("oe", 8'h31, oe);
      chk("pad", 8'h21, opad & oe);
      @(posedge clk) tg <= 8'h01;
      @(posedge clk) tg <= 8'h00;
      rd(PPO_IDX_OUT, 8'hFE);
      @(posedge clk) {pu_e, dd_e, pv_e} <= 24'h000000;
      wr(PPO_IDX_CTRL, 8'h00);
   endtask
   task automatic t_sleep();
      wr(PPO_IDX_DIR, 8'h00);
      @(posedge clk) {xv, slp, xe, ie_e, ie_v} <= {8'hFF, 1'b1, 8'h01, 8'h06, 8'h02};
      #1 chk("tap", 8'h03, tap);
      repeat (3) @(posedge clk);
      rd(PPO_IDX_INPUT, 8'h03);
      @(posedge clk) {xe, ie_e} <= 16'h0000;
      wr(PPO_IDX_CTRL, 8'h06);
      wr(PPO_IDX_FLAG, 8'hFF);
      chk("flag", 8'h00, flag);
      @(posedge clk) slp <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk("flag", 8'hFF, flag);
      rd(PPO_IDX_INPUT, 8'hFF);
   endtask
   initial begin
      {nrst, wr_s, rd_s, slp, addr, wd, pu_e, pu_v, dd_e, dd_v, pv_e, pv_v, tg, ie_e, ie_v, xe, xv} = '0;
      xen = 8'hFF;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_gpio();
      t_ovr();
      t_sleep();
      finish_test();
   end
endmodule // port_pin_override_and_sleep_clamp_tb
`default_nettype wire
